// ---- crit_temp_consts.svh ----
/*
 Constants for the critical-output status registers: command bytes,
 field positions, reset values and widths.
 Assumes inclusion by bare name from the package and the design files.
*/
`ifndef CRIT_TEMP_CONSTS_SVH
`define CRIT_TEMP_CONSTS_SVH

// ==========================================================
// Command bytes
`define CMD_SECOND_STATUS 8'h09
`define CMD_THIRD_STATUS  8'h0a
`define READ_UNMAPPED     8'h00

// ==========================================================
// Field layout
`define TEMP_W            11
`define STATUS_W          5
`define RSVD_ZERO         3'h0
`define CH_LOCAL          0
`define CH_REM1           1
`define CH_REM2           2
`define CH_REM3           3
`define CH_REM4           4
`define OUT_SECOND        0
`define OUT_THIRD         1

// ==========================================================
// Reset values
`define STATUS_BIT_RST    1'h0
`define STATUS_RST        5'h00
`define OUT_INACTIVE      1'h1
`define FLAG_RST          1'h0

`endif

// ---- crit_temp_pkg.sv ----
/*
 Types and compare functions shared by the status cell and the
 status register bank.
 Assumes crit_temp_consts.svh is on the include path.
*/
`include "crit_temp_consts.svh"

package crit_temp_pkg;

   // ==========================================================
   // Carriers
   typedef logic signed [`TEMP_W-1:0] temp_t;
   typedef logic        [`TEMP_W-1:0] hyst_t;
   typedef logic        [`STATUS_W-1:0] chan_vec_t;

   typedef struct packed {
      chan_vec_t         done;
      temp_t [4:0]       reading;
   } conv_bus_t;

   typedef struct packed {
      temp_t [2:0]       single_limit;
      temp_t [1:0]       second_limit;
      hyst_t             hyst;
   } limit_bus_t;

   typedef struct packed {
      chan_vec_t         second;
      chan_vec_t         third;
   } mask_bus_t;

   // ==========================================================
   // Compare functions
   function automatic logic at_or_above(temp_t rd, temp_t lim);
      return rd >= lim;
   endfunction : at_or_above

   // Two extra bits: lowest limit minus largest hysteresis must not wrap
   function automatic logic below_release(temp_t rd, temp_t lim, hyst_t hy);
      logic signed [`TEMP_W+1:0] rel;
      rel = $signed({{2{lim[`TEMP_W-1]}}, lim}) - $signed({2'b00, hy});
      return $signed({{2{rd[`TEMP_W-1]}}, rd}) < rel;
   endfunction : below_release

endpackage : crit_temp_pkg

// ---- crit_temp_status.sv ----
/*
 Status registers behind the second and third critical outputs,
 their active-low outputs, summary flags and command-byte read port.
 Assumes conversion results, limits, hysteresis and masks come from
 logic on ref_clk; the serial slave drives rd_req and rd_cmd.
*/
// How it works
// RL1: Command byte 0x09 reads the second output's status, remote 4 down to local in bits 4..0.
// RL2: Command byte 0x0a reads the third output's status with the same bit order.
// RL3: Bits 7..5 of both status registers always read as zero.
// RL4: A channel bit sets when its newest reading is at or above its critical limit.
// RL5: A set bit clears only when the reading is below the limit minus the shared hysteresis.
// RL6: Remotes 1 and 2 use their second critical limit; local, remote 3 and 4 use their single limit.
// RL7: The third output goes active while any unmasked bit of its status is set.
// RL8: The third output goes inactive once all its status bits are clear.
// RL9: The second output follows its unmasked status bits the same way.
// RL10: Between release level and limit a channel bit keeps its old value.
// RL11: A mask bit of one keeps that channel from driving the output; zero lets it through.
// RL12: Each summary flag reads one while its status register has any bit set.
`timescale 1ns/100ps
`default_nettype none
`include "crit_temp_consts.svh"

module crit_temp_status
   import crit_temp_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // Conversion engine
   input  wire conv_bus_t   conv,
   // Limits and hysteresis
   input  wire limit_bus_t  limits,
   // Output masks
   input  wire mask_bus_t   masks,
   // Command-byte read port
   input  wire logic        rd_req,
   input  wire logic [7:0]  rd_cmd,
   output logic      [7:0]  rd_data_r,
   output logic             rd_ack_r,
   // Critical outputs, active low
   output logic             crit_out_second_n,
   output logic             crit_out_third_n,
   // Summary flags for the main status register
   output logic             second_status_summary,
   output logic             third_status_summary
);

   // ==========================================================
   // Decoding helpers
   function automatic temp_t chan_limit(limit_bus_t l, int ch);
      temp_t r;
      r = l.single_limit[0];
      case (ch)
         `CH_REM1: begin
            r = l.second_limit[0];
         end
         `CH_REM2: begin
            r = l.second_limit[1];
         end
         `CH_REM3: begin
            r = l.single_limit[1];
         end
         `CH_REM4: begin
            r = l.single_limit[2];
         end
         default: begin
            r = l.single_limit[0];
         end
      endcase
      return r;
   endfunction : chan_limit

   function automatic logic [7:0] read_mux(logic [7:0] cmd,
                                           chan_vec_t s2,
                                           chan_vec_t s3);
      logic [7:0] d;
      d = `READ_UNMAPPED;
      case (cmd)
         `CMD_SECOND_STATUS: begin
            d = {`RSVD_ZERO, s2};
         end
         `CMD_THIRD_STATUS: begin
            d = {`RSVD_ZERO, s3};
         end
         default: begin
            d = `READ_UNMAPPED;
         end
      endcase
      return d;
   endfunction : read_mux

   // ==========================================================
   // Status bits
   // Both registers share one limit set, so only the masks tell them apart
   chan_vec_t  st_second;
   chan_vec_t  st_third;
   temp_t      eff_lim [`STATUS_W];

   genvar ch;
   generate
      for (ch = 0; ch < `STATUS_W; ch++) begin : g_chan
         // Remotes 1 and 2 watch their second limit here
         assign eff_lim[ch] = chan_limit(limits, ch); // [RL6]

         hyst_status_cell u_second (
            .ref_clk  (ref_clk),
            .rst_n    (rst_n),
            .sample   (conv.done[ch]),
            .reading  (conv.reading[ch]),
            .limit    (eff_lim[ch]),
            .hyst     (limits.hyst),
            .status_r (st_second[ch])
         );

         hyst_status_cell u_third (
            .ref_clk  (ref_clk),
            .rst_n    (rst_n),
            .sample   (conv.done[ch]),
            .reading  (conv.reading[ch]),
            .limit    (eff_lim[ch]),
            .hyst     (limits.hyst),
            .status_r (st_third[ch])
         );

         // Per-channel checks
         sequence s_conv_hit;
            conv.done[ch] && at_or_above(conv.reading[ch], eff_lim[ch]);
         endsequence

         sequence s_conv_drop;
            conv.done[ch] && below_release(conv.reading[ch], eff_lim[ch], limits.hyst)
               && !at_or_above(conv.reading[ch], eff_lim[ch]);
         endsequence

         sequence s_conv_band;
            conv.done[ch] && !at_or_above(conv.reading[ch], eff_lim[ch])
               && !below_release(conv.reading[ch], eff_lim[ch], limits.hyst);
         endsequence

         a_set_at_limit: assert property ( // [RL4]
            @(posedge ref_clk) disable iff (!rst_n)
            s_conv_hit |=> st_second[ch] && st_third[ch])
            else $error("status bit not set at limit");

         a_clear_below_release: assert property ( // [RL5]
            @(posedge ref_clk) disable iff (!rst_n)
            s_conv_drop |=> !st_second[ch] && !st_third[ch])
            else $error("status bit not cleared below release");

         a_hold_in_band: assert property ( // [RL10]
            @(posedge ref_clk) disable iff (!rst_n)
            s_conv_band |=> st_second[ch] == $past(st_second[ch])
               && st_third[ch] == $past(st_third[ch]))
            else $error("status bit moved inside hysteresis band");

         a_idle_hold: assert property ( // [RL10]
            @(posedge ref_clk) disable iff (!rst_n)
            !conv.done[ch] |=> $stable(st_second[ch]))
            else $error("status bit moved without a conversion");

         a_third_idle_hold: assert property ( // [RL10]
            @(posedge ref_clk) disable iff (!rst_n)
            !conv.done[ch] |=> $stable(st_third[ch]))
            else $error("third status bit moved without a conversion");
      end
   endgenerate

   // ==========================================================
   // Critical outputs and summary flags
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         crit_out_second_n <= `OUT_INACTIVE;
      end else begin
         crit_out_second_n <= ~|(st_second & ~masks.second); // [RL9] [RL11]
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         crit_out_third_n <= `OUT_INACTIVE;
      end else begin
         // Active while any unmasked bit stands, released when none [RL7] [RL8]
         crit_out_third_n <= ~|(st_third & ~masks.third); // [RL11]
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         second_status_summary <= `FLAG_RST;
         third_status_summary  <= `FLAG_RST;
      end else begin
         // Flags ignore masks: they tell software a bit stands
         second_status_summary <= |st_second; // [RL12]
         third_status_summary  <= |st_third;  // [RL12]
      end
   end

   // ==========================================================
   // Command-byte read port
   // A request held high answers again every cycle, so hosts pulse it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_ack_r <= 1'b0;
      end else begin
         rd_ack_r <= rd_req;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_r <= `READ_UNMAPPED;
      end else if (rd_req) begin
         // Snapshot taken at the request edge [RL1] [RL2] [RL3]
         rd_data_r <= read_mux(rd_cmd, st_second, st_third);
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge ref_clk);
   endclocking

   default disable iff (!rst_n);

   sequence s_read_second;
      rd_req && rd_cmd == `CMD_SECOND_STATUS;
   endsequence

   sequence s_read_third;
      rd_req && rd_cmd == `CMD_THIRD_STATUS;
   endsequence

   sequence s_read_unmapped;
      rd_req && rd_cmd != `CMD_SECOND_STATUS && rd_cmd != `CMD_THIRD_STATUS;
   endsequence

   a_read_second_map: assert property ( // [RL1]
      s_read_second |=> rd_ack_r && rd_data_r == {`RSVD_ZERO, $past(st_second)})
      else $error("second status read returned wrong data");

   a_read_third_map: assert property ( // [RL2]
      s_read_third |=> rd_ack_r && rd_data_r == {`RSVD_ZERO, $past(st_third)})
      else $error("third status read returned wrong data");

   a_read_unmapped: assert property ( // [RL3]
      s_read_unmapped |=> rd_ack_r && rd_data_r == `READ_UNMAPPED)
      else $error("unmapped command byte did not read as zero");

   a_ack_follows: assert property ( // [RL1]
      rd_req |=> rd_ack_r)
      else $error("read request got no answer");

   // Data must stand until the next request so a slow host still sees it
   a_data_holds: assert property ( // [RL1]
      !rd_req |=> $stable(rd_data_r))
      else $error("read data changed without a request");

   a_rsvd_zero: assert property ( // [RL3]
      rd_ack_r |-> rd_data_r[7:5] == `RSVD_ZERO)
      else $error("reserved status bits not zero");

   a_cells_agree: assert property ( // [RL6]
      st_second == st_third)
      else $error("second and third status registers disagree");

   a_third_out_active: assert property ( // [RL7]
      |(st_third & ~masks.third) |=> !crit_out_third_n)
      else $error("third output not active with unmasked bit set");

   a_third_out_release: assert property ( // [RL8]
      st_third == `STATUS_RST |=> crit_out_third_n)
      else $error("third output still active with all bits clear");

   a_second_out_active: assert property ( // [RL9]
      |(st_second & ~masks.second) |=> !crit_out_second_n)
      else $error("second output not active with unmasked bit set");

   a_second_out_release: assert property ( // [RL9]
      st_second == `STATUS_RST |=> crit_out_second_n)
      else $error("second output still active with all bits clear");

   a_second_out_follow: assert property ( // [RL9]
      ##1 crit_out_second_n == !$past(|(st_second & ~masks.second)))
      else $error("second output does not follow its status");

   a_mask_blocks_second: assert property ( // [RL11]
      (st_second & ~masks.second) == `STATUS_RST |=> crit_out_second_n)
      else $error("masked channel drove second output");

   a_mask_blocks_third: assert property ( // [RL11]
      (st_third & ~masks.third) == `STATUS_RST |=> crit_out_third_n)
      else $error("masked channel drove third output");

   a_summary_flags: assert property ( // [RL12]
      ##1 second_status_summary == $past(|st_second)
         && third_status_summary == $past(|st_third))
      else $error("summary flag disagrees with status register");

   a_ack_pulse: assert property ( // [RL1]
      rd_ack_r && !$past(rd_req) |-> 1'b0)
      else $error("read answer without request");

endmodule : crit_temp_status

`default_nettype wire

// ---- hyst_status_cell.sv ----
/*
 One channel status bit with set-at-limit, clear-below-release and
 hold in between.
 Assumes a sample strobe on the same clock, one cycle per conversion.
*/
`timescale 1ns/100ps
`default_nettype none
`include "crit_temp_consts.svh"

module hyst_status_cell
   import crit_temp_pkg::*;
(
   // Clock and reset
   input  wire logic    ref_clk,
   input  wire logic    rst_n,
   // Conversion result
   input  wire logic    sample,
   input  wire temp_t   reading,
   input  wire temp_t   limit,
   input  wire hyst_t   hyst,
   // Status
   output logic         status_r
);

   logic status_nxt;

   // ==========================================================
   // Hysteresis decision
   always_comb begin
      status_nxt = status_r;
      if (sample) begin
         if (at_or_above(reading, limit)) begin
            status_nxt = 1'b1; // [RL4]
         end else if (below_release(reading, limit, hyst)) begin
            status_nxt = 1'b0; // [RL5]
         end
         // Inside the band the bit keeps its value [RL10]
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_r <= `STATUS_BIT_RST;
      end else begin
         status_r <= status_nxt;
      end
   end

endmodule : hyst_status_cell

`default_nettype wire

// ---- status_host_model.sv ----
/*
 Behavioural host that fetches status bytes by command byte.
 Assumes the read port contract: one-cycle request, answer one cycle later.
*/
`timescale 1ns/100ps
`default_nettype none

module status_host_model (
   // Clock
   input  wire logic       ref_clk,
   // Read port
   output logic            rd_req,
   output logic [7:0]      rd_cmd,
   input  wire logic [7:0] rd_data_r,
   input  wire logic       rd_ack_r
);
   initial begin
      rd_req = 1'b0;
      rd_cmd = 8'h00;
   end

   // ==========================================================
   // Single-byte read, answer awaited for a bounded time
   task automatic do_read(input logic [7:0] cmd, output logic [7:0] d, output logic ok);
      ok = 1'b0;
      d = 8'h00;
      @(posedge ref_clk);
      #1;
      rd_req = 1'b1;
      rd_cmd = cmd;
      @(posedge ref_clk);
      #1;
      rd_req = 1'b0;
      // Released byte carries the inverted command so a stale command cannot pass
      rd_cmd = ~cmd;
      for (int i = 0; i < 8 && !ok; i++) begin
         if (rd_ack_r === 1'b1) begin
            ok = 1'b1;
            d = rd_data_r;
         end else begin
            @(posedge ref_clk);
            #1;
         end
      end
   endtask : do_read
endmodule : status_host_model
`default_nettype wire

// ---- test_critical_temp_status_regs.sv ----
/*
 Self-checking bench for the critical-output status registers.
 Assumes the host model drives the read port; the bench plays the
 conversion engine, limit and mask registers.
*/
`timescale 1ns/100ps
`default_nettype none
`include "crit_temp_consts.svh"

module test_critical_temp_status_regs;
   import crit_temp_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   conv_bus_t   conv = '0;
   limit_bus_t  limits;
   mask_bus_t   masks = '0;
   logic        rd_req;
   logic [7:0]  rd_cmd;
   logic [7:0]  rd_data_r;
   logic        rd_ack_r;
   logic        crit_out_second_n;
   logic        crit_out_third_n;
   logic        second_status_summary;
   logic        third_status_summary;
   int          n_errors = 0;
   int          checked = 0;

   always #10 ref_clk = ~ref_clk;

   crit_temp_status dut (.ref_clk(ref_clk), .rst_n(rst_n), .conv(conv), .limits(limits),
      .masks(masks), .rd_req(rd_req), .rd_cmd(rd_cmd), .rd_data_r(rd_data_r),
      .rd_ack_r(rd_ack_r), .crit_out_second_n(crit_out_second_n),
      .crit_out_third_n(crit_out_third_n), .second_status_summary(second_status_summary),
      .third_status_summary(third_status_summary));

   status_host_model host (.ref_clk(ref_clk), .rd_req(rd_req), .rd_cmd(rd_cmd),
      .rd_data_r(rd_data_r), .rd_ack_r(rd_ack_r));

   // ==========================================================
   // Helpers
   // Distinct limits per channel so a swapped limit shows up
   function automatic temp_t lim(int ch);
      temp_t t[5] = '{11'h064, 11'h050, 11'h05a, 11'h06e, 11'h078};
      return t[ch];
   endfunction : lim

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test

   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic rd(logic [7:0] cmd, logic [7:0] e);
      logic [7:0] d;
      logic       ok;
      host.do_read(cmd, d, ok);
      if (ok !== 1'b1) begin
         n_errors++;
         $display("BAD read answer to %h expected 1 seen %b", cmd, ok);
         finish_test();
      end else begin
         chk("read data", e, d);
      end
   endtask : rd

   // Outputs packed as {second_n, third_n, second_summary, third_summary}
   task automatic co(logic [3:0] e);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("outputs", {4'h0, e}, {4'h0, crit_out_second_n, crit_out_third_n,
          second_status_summary, third_status_summary});
   endtask : co

   task automatic cv(int ch, temp_t v);
      @(posedge ref_clk);
      #1;
      conv.done = 5'h01 << ch;
      conv.reading[ch] = v;
      @(posedge ref_clk);
      #1;
      conv.done = '0;
   endtask : cv

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      co(4'hc);
      rd(`CMD_SECOND_STATUS, 8'h00);
      rd(`CMD_THIRD_STATUS, 8'h00);
      $display("test reset done");
   endtask : t_reset

   task automatic t_set();
      for (int ch = 0; ch < 5; ch++) begin
         cv(ch, lim(ch) - 1);
         rd(`CMD_SECOND_STATUS, 8'h1f >> (5 - ch));
         cv(ch, lim(ch));
         rd(`CMD_SECOND_STATUS, 8'h1f >> (4 - ch));
         rd(`CMD_THIRD_STATUS, 8'h1f >> (4 - ch));
         co(4'h3);
      end
      $display("test set done");
   endtask : t_set

   task automatic t_hyst();
      for (int ch = 0; ch < 5; ch++) begin
         // Exactly at release level is not below it, so the bit holds
         cv(ch, lim(ch) - 5);
         rd(`CMD_SECOND_STATUS, 8'h1f & ~((8'h01 << ch) - 8'h01));
         cv(ch, lim(ch) - 6);
         rd(`CMD_THIRD_STATUS, 8'h1f & ~((8'h01 << (ch + 1)) - 8'h01));
      end
      co(4'hc);
      $display("test hysteresis done");
   endtask : t_hyst

   task automatic t_mask();
      masks = {5'h01, 5'h1f};
      cv(0, lim(0) + 50);
      co(4'hf);
      @(posedge ref_clk);
      #1;
      masks = {5'h00, 5'h1e};
      // Summaries ignore masks, so they stay high with the local bit set
      co(4'h3);
      rd(8'h0b, 8'h00);
      rd(`CMD_SECOND_STATUS, 8'h01);
      cv(0, lim(0) - 6);
      co(4'hc);
      $display("test mask done");
   endtask : t_mask

   // Reset in mid-run must drop a standing bit and free the second output; the third stays masked off
   task automatic t_midreset();
      cv(`CH_REM3, lim(3));
      co(4'h7);
      rst_n = 1'b0;
      co(4'hc);
      rst_n = 1'b1;
      rd(`CMD_THIRD_STATUS, 8'h00);
      co(4'hc);
      $display("test mid-run reset done");
   endtask : t_midreset

   initial begin
      limits = {lim(4), lim(3), lim(0), lim(2), lim(1), 11'h005};
      repeat (12) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      t_reset();
      t_set();
      t_hyst();
      t_mask();
      t_midreset();
      finish_test();
   end
endmodule : test_critical_temp_status_regs
`default_nettype wire
